/* rtl/tcc_params.svh */
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// register byte offsets on the apb bus
`define TCC_OFF_CONTROL    12'h000
`define TCC_OFF_MODE       12'h004
`define TCC_OFF_SYNC       12'h008
`define TCC_OFF_STATUS     12'h00C

// counter_control field positions
`define TCC_CLR_MSB        7
`define TCC_CLR_LSB        5
`define TCC_EDGE_MSB       4
`define TCC_EDGE_LSB       3
`define TCC_EDGE_BOTH_BIT  4
`define TCC_PSC_MSB        2
`define TCC_PSC_LSB        0
`define TCC_CONTROL_RESET  8'h00

// channel mode register fields
`define TCC_MODE_PHASE_BIT 0
`define TCC_MODE_BUFC_BIT  1
`define TCC_MODE_BUFD_BIT  2
`define TCC_MODE_RESET     3'h0

// synchro register field
`define TCC_SYNC_BIT       0
`define TCC_SYNC_RESET     1'b0

// status register fields
`define TCC_STAT_INC_BIT   0
`define TCC_STAT_CLR_BIT   1
`define TCC_STAT_LVL_BIT   2
`define TCC_STAT_RUN_BIT   3

// prescaler taps: bit n of the free counter toggles every 2^n clocks
`define TCC_TAP4_BIT       1
`define TCC_TAP16_BIT      3
`define TCC_TAP64_BIT      5
`define TCC_PSC_WIDTH      6

`endif

/* rtl/tcc_pkg.sv */
package tcc_pkg;

    typedef enum logic [2:0] {
        TCC_CLR_NONE0 = 3'h0,
        TCC_CLR_A     = 3'h1,
        TCC_CLR_B     = 3'h2,
        TCC_CLR_SYNC0 = 3'h3,
        TCC_CLR_NONE1 = 3'h4,
        TCC_CLR_C     = 3'h5,
        TCC_CLR_D     = 3'h6,
        TCC_CLR_SYNC1 = 3'h7
    } tcc_clear_t;

    typedef enum logic [1:0] {
        TCC_EDGE_RISE  = 2'h0,
        TCC_EDGE_FALL  = 2'h1,
        TCC_EDGE_BOTH0 = 2'h2,
        TCC_EDGE_BOTH1 = 2'h3
    } tcc_edge_t;

    typedef enum logic [2:0] {
        TCC_PSC_DIV1  = 3'h0,
        TCC_PSC_DIV4  = 3'h1,
        TCC_PSC_DIV16 = 3'h2,
        TCC_PSC_DIV64 = 3'h3,
        TCC_PSC_EXTA  = 3'h4,
        TCC_PSC_EXTB  = 3'h5,
        TCC_PSC_EXTC  = 3'h6,
        TCC_PSC_EXTD  = 3'h7
    } tcc_psc_t;

endpackage

/* rtl/tcc_timer_clock_clear.sv */
// What this block does
// - bits 7 to 5 of counter_control are a read/write clear-source field, all reset to zero.
// - edge field code 00 counts rising edges, 01 falling edges, 1x both edges.
// - counting both edges halves the period, so the quarter tap acts like a half-rate clock.
// - in phase counting mode the edge field is ignored and only phase steps advance the counter.
// - edge selection on an internal prescaled clock applies only to the quarter tap or slower.
// - with the undivided clock and rising edge selected the counter advances every system clock.
// - bits 2 to 0 are a read/write prescaler field, held independently by this channel.
// - clear codes 000 and 100 disable counter clearing, 000 being the reset state.
// - code 001 clears on a match or capture of register a, code 010 on register b.
// - code 101 clears on a match or capture of register c, code 110 on register d.
// - codes 011 and 111 clear when another synchronously operating channel clears.
// - synchronous clearing applies only when this channel's synchro bit is one.
// - a c or d register used as a buffer gives no match or capture and never clears.
// - prescaler codes 000 to 011 pick clock / 1, 4, 16, 64; codes 100 to 111 pick pins a to d.
`include "tcc_params.svh"

module tcc_timer_clock_clear
    import tcc_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  ext_clock_pin_a,
    input  wire logic                  ext_clock_pin_b,
    input  wire logic                  ext_clock_pin_c,
    input  wire logic                  ext_clock_pin_d,
    input  wire logic                  counter_run,
    input  wire logic                  phase_step,
    input  wire logic                  match_a,
    input  wire logic                  match_b,
    input  wire logic                  match_c,
    input  wire logic                  match_d,
    input  wire logic                  sync_clear_in,
    output logic                       count_inc,
    output logic                       count_clear,
    output logic                       sync_clear_out
);

    logic [7:0]                counter_control_reg;
    logic [2:0]                channel_mode_reg;
    logic                      sync_enable_reg;
    logic [`TCC_PSC_WIDTH-1:0] div_cnt_reg;
    logic [3:0]                pin_meta_reg;
    logic [3:0]                pin_sync_reg;
    logic                      src_prev_reg;
    logic                      count_inc_reg;
    logic                      count_clear_reg;
    logic [31:0]               prdata_reg;
    logic                      pslverr_reg;
    logic                      count_inc_next;
    logic                      count_clear_next;
    logic                      src_level;
    logic                      setup_phase;
    logic                      wr_access;
    logic                      addr_hit;
    logic [31:0]               rd_value;
    tcc_clear_t                clear_sel;
    tcc_edge_t                 edge_sel;
    tcc_psc_t                  psc_sel;

    assign clear_sel = tcc_clear_t'(counter_control_reg[`TCC_CLR_MSB:`TCC_CLR_LSB]);
    assign edge_sel  = tcc_edge_t'(counter_control_reg[`TCC_EDGE_MSB:`TCC_EDGE_LSB]);
    assign psc_sel   = tcc_psc_t'(counter_control_reg[`TCC_PSC_MSB:`TCC_PSC_LSB]);

    // level of the selected counting source
    function automatic logic pick_source(
        input tcc_psc_t                  sel,
        input logic [`TCC_PSC_WIDTH-1:0] taps,
        input logic [3:0]                pins
    );
        logic lvl;
        lvl = 1'b0;
        unique case (sel)
            TCC_PSC_DIV1:  lvl = 1'b1;
            TCC_PSC_DIV4:  lvl = taps[`TCC_TAP4_BIT];
            TCC_PSC_DIV16: lvl = taps[`TCC_TAP16_BIT];
            TCC_PSC_DIV64: lvl = taps[`TCC_TAP64_BIT];
            TCC_PSC_EXTA:  lvl = pins[0];
            TCC_PSC_EXTB:  lvl = pins[1];
            TCC_PSC_EXTC:  lvl = pins[2];
            TCC_PSC_EXTD:  lvl = pins[3];
        endcase
        return lvl;
    endfunction

    // edge detection against the previous level
    function automatic logic edge_hit(
        input tcc_edge_t sel,
        input logic      prev,
        input logic      cur
    );
        logic hit;
        hit = 1'b0;
        unique case (sel)
            TCC_EDGE_RISE:  hit = cur & ~prev;
            TCC_EDGE_FALL:  hit = prev & ~cur;
            TCC_EDGE_BOTH0: hit = cur ^ prev;
            TCC_EDGE_BOTH1: hit = cur ^ prev;
        endcase
        return hit;
    endfunction

    // clear request for a given clear code
    function automatic logic clear_hit(
        input tcc_clear_t sel,
        input logic       ma,
        input logic       mb,
        input logic       mc,
        input logic       md,
        input logic       sync_ok
    );
        logic hit;
        hit = 1'b0;
        unique case (sel)
            TCC_CLR_NONE0: hit = 1'b0;
            TCC_CLR_NONE1: hit = 1'b0;
            TCC_CLR_A:     hit = ma;
            TCC_CLR_B:     hit = mb;
            TCC_CLR_C:     hit = mc;
            TCC_CLR_D:     hit = md;
            TCC_CLR_SYNC0: hit = sync_ok;
            TCC_CLR_SYNC1: hit = sync_ok;
        endcase
        return hit;
    endfunction

    // free-running prescaler, taps give the divided clocks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_reg <= '0;
        end
        else
        begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    // two-stage synchroniser for the external clock pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end
        else
        begin
            pin_meta_reg <= {ext_clock_pin_d, ext_clock_pin_c, ext_clock_pin_b, ext_clock_pin_a};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign src_level = pick_source(psc_sel, div_cnt_reg, pin_sync_reg);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_prev_reg <= 1'b0;
        end
        else
        begin
            src_prev_reg <= src_level;
        end
    end

    // increment decision; both-edge counting on a tap of period p gives a step every p/2 clocks
    always_comb
    begin
        count_inc_next = 1'b0;
        if (counter_run)
        begin
            if (channel_mode_reg[`TCC_MODE_PHASE_BIT])
            begin
                count_inc_next = phase_step;
            end
            else if (psc_sel == TCC_PSC_DIV1)
            begin
                count_inc_next = 1'b1;
            end
            else
            begin
                count_inc_next = edge_hit(edge_sel, src_prev_reg, src_level);
            end
        end
    end

    // clear decision; buffered c or d registers are masked before the decode
    always_comb
    begin
        count_clear_next = clear_hit(
            clear_sel,
            match_a,
            match_b,
            match_c & ~channel_mode_reg[`TCC_MODE_BUFC_BIT],
            match_d & ~channel_mode_reg[`TCC_MODE_BUFD_BIT],
            sync_clear_in & sync_enable_reg
        );
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_inc_reg   <= 1'b0;
            count_clear_reg <= 1'b0;
        end
        else
        begin
            count_inc_reg   <= count_inc_next;
            count_clear_reg <= count_clear_next;
        end
    end

    assign count_inc   = count_inc_reg;
    assign count_clear = count_clear_reg;
    // a following channel only sees our clear when we take part in sync; registered, so no loop
    // sync bit gates
    assign sync_clear_out = count_clear_reg & sync_enable_reg;

    // apb decode: one wait-free access, answer computed in the setup cycle
    assign setup_phase = psel & ~penable;
    assign wr_access   = psel & penable & pwrite;
    assign addr_hit    = (paddr == `TCC_OFF_CONTROL) || (paddr == `TCC_OFF_MODE) ||
                         (paddr == `TCC_OFF_SYNC) || (paddr == `TCC_OFF_STATUS);

    // writes are taken even while counting; keeping the counter stopped is software's job
    // control register write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            counter_control_reg <= `TCC_CONTROL_RESET;
        end
        else if (wr_access && pstrb[0] && paddr == `TCC_OFF_CONTROL)
        begin
            counter_control_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            channel_mode_reg <= `TCC_MODE_RESET;
        end
        else if (wr_access && pstrb[0] && paddr == `TCC_OFF_MODE)
        begin
            channel_mode_reg <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_enable_reg <= `TCC_SYNC_RESET;
        end
        else if (wr_access && pstrb[0] && paddr == `TCC_OFF_SYNC)
        begin
            sync_enable_reg <= pwdata[`TCC_SYNC_BIT];
        end
    end

    always_comb
    begin
        rd_value = 32'h0000_0000;
        unique case (paddr)
            `TCC_OFF_CONTROL: rd_value[7:0] = counter_control_reg;
            `TCC_OFF_MODE:    rd_value[2:0] = channel_mode_reg;
            `TCC_OFF_SYNC:    rd_value[`TCC_SYNC_BIT] = sync_enable_reg;
            `TCC_OFF_STATUS:
            begin
                rd_value[`TCC_STAT_INC_BIT] = count_inc_reg;
                rd_value[`TCC_STAT_CLR_BIT] = count_clear_reg;
                rd_value[`TCC_STAT_LVL_BIT] = src_level;
                rd_value[`TCC_STAT_RUN_BIT] = counter_run;
            end
            default:          rd_value = 32'h0000_0000;
        endcase
    end

    // read data and error latched in the setup cycle so both come from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_value;
            pslverr_reg <= ~addr_hit;
        end
    end

    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg & psel & penable;
    assign pready  = psel & penable;

endmodule // tcc_timer_clock_clear

/* verif/tcc_timer_clock_clear_props.sv */
`include "tcc_params.svh"

module tcc_timer_clock_clear_props
    import tcc_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  counter_run,
    input wire logic                  phase_step,
    input wire logic                  match_a,
    input wire logic                  match_b,
    input wire logic                  match_c,
    input wire logic                  match_d,
    input wire logic                  sync_clear_in,
    input wire logic                  count_inc,
    input wire logic                  count_clear,
    input wire logic                  sync_clear_out
);
    logic [7:0] ctl_reg;
    logic       phase_reg;
    logic       wr_en;

    // shadows follow completed writes only, so a refused strobe never moves them
    assign wr_en = psel && penable && pwrite && pstrb[0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl_reg <= 8'h00;
        else if (wr_en && paddr == `TCC_OFF_CONTROL)
            ctl_reg <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_reg <= 1'b0;
        else if (wr_en && paddr == `TCC_OFF_MODE)
            phase_reg <= pwdata[0];
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence rd_ctl_s;
        psel && penable && !pwrite && paddr == `TCC_OFF_CONTROL;
    endsequence
    sequence any_cause_s;
        $past(match_a | match_b | match_c | match_d | sync_clear_in);
    endsequence

    ready_follow_a: assert property (pready == (psel && penable))
        else $error("pready does not follow the access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside an access phase");
    ctl_read_a: assert property (rd_ctl_s |-> prdata == {24'h0000_00, ctl_reg})
        else $error("control read differs from last write");
    run_gate_a: assert property (count_inc |-> $past(counter_run))
        else $error("count_inc while stopped");
    clear_cause_a: assert property (count_clear |-> any_cause_s)
        else $error("count_clear with no cause");
    clear_none_a: assert property (count_clear |-> $past(ctl_reg[6:5]) != 2'h0)
        else $error("count_clear with clearing disabled");
    clear_src_a: assert property (match_a && ctl_reg[7:5] == 3'h1 |=> count_clear)
        else $error("match a did not clear");
    sync_out_a: assert property (sync_clear_out |-> count_clear)
        else $error("sync_clear_out without count_clear");
    div1_every_a: assert property
        (counter_run && ctl_reg[2:0] == 3'h0 && !phase_reg |=> count_inc)
        else $error("undivided clock missed a count");
    phase_hold_a: assert property (phase_reg && !phase_step |=> !count_inc)
        else $error("count_inc in phase mode without a step");
endmodule // tcc_timer_clock_clear_props

bind tcc_timer_clock_clear tcc_timer_clock_clear_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counter_run(counter_run), .phase_step(phase_step),
    .match_a(match_a), .match_b(match_b), .match_c(match_c), .match_d(match_d),
    .sync_clear_in(sync_clear_in), .count_inc(count_inc), .count_clear(count_clear),
    .sync_clear_out(sync_clear_out));

/* verif/tcc_timer_clock_clear_bench.sv */
`include "tcc_params.svh"

module tcc_timer_clock_clear_bench
    import tcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, er, count_inc, count_clear, sync_clear_out;
    logic        counter_run = 0, phase_step = 0;
    logic [4:0]  ev = '0;
    logic [7:0]  tg = '0;
    int          err_count = 0, n_tests = 0;

    always #5 pclk = ~pclk;
    // free toggles give the four pins distinct rates: 8, 16, 32, 64 clocks
    always @(posedge pclk) tg <= tg + 8'h01;

    tcc_timer_clock_clear dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clock_pin_a(tg[2]), .ext_clock_pin_b(tg[3]), .ext_clock_pin_c(tg[4]),
        .ext_clock_pin_d(tg[5]), .counter_run(counter_run), .phase_step(phase_step),
        .match_a(ev[0]), .match_b(ev[1]), .match_c(ev[2]), .match_d(ev[3]),
        .sync_clear_in(ev[4]), .count_inc(count_inc), .count_clear(count_clear),
        .sync_clear_out(sync_clear_out));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a slave that never answers
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cnt(input int n, output int c);
        c = 0;
        repeat (n) @(posedge pclk) if (count_inc === 1'b1) c++;
    endtask

    task automatic t_regs();
        apb(0, `TCC_OFF_CONTROL, 0);
        chk("ctl_reset", rd, 32'h0000_0000);
        apb(1, `TCC_OFF_CONTROL, 32'hFFFF_FFFF);
        apb(0, `TCC_OFF_CONTROL, 0);
        chk("ctl_all", rd, 32'h0000_00FF);
        apb(1, `TCC_OFF_CONTROL, 32'h0000_00A5);
        apb(0, `TCC_OFF_CONTROL, 0);
        chk("ctl_mix", rd, 32'h0000_00A5);
        apb(0, 12'h010, 0);
        chk("unmapped", {31'h0, er}, 32'h0000_0001);
    endtask

    task automatic t_rates();
        int div[8] = '{1, 4, 16, 64, 8, 16, 32, 64};
        int c;
        for (int p = 0; p < 8; p++)
            for (int g = 0; g < 4; g++)
            begin
                counter_run <= 1'b0;
                apb(1, `TCC_OFF_CONTROL, {27'h0, g[1:0], p[2:0]});
                counter_run <= 1'b1;
                repeat (8) @(posedge pclk);
                cnt(128, c);
                // both edges halve the period, except on the undivided clock
                if (p == 0)
                    chk("inc_div1", c, 128);
                else if (g >= 2)
                    chk("inc_both", c, 256 / div[p]);
                else if (g == 1)
                    chk("inc_fall", c, 128 / div[p]);
                else if (p < 4)
                    chk("inc_tap", c, 128 / div[p]);
                else
                    chk("inc_pin", c, 128 / div[p]);
            end
    endtask

    task automatic t_clears();
        logic x;
        counter_run <= 1'b0;
        for (int s = 0; s < 2; s++)
            for (int b = 0; b < 2; b++)
                for (int c = 0; c < 8; c++)
                begin
                    apb(1, `TCC_OFF_SYNC, s);
                    apb(1, `TCC_OFF_MODE, b * 6);
                    apb(1, `TCC_OFF_CONTROL, c << 5);
                    for (int i = 0; i < 5; i++)
                    begin
                        x = (c == 1 && i == 0) || (c == 2 && i == 1) || (c == 5 && i == 2
                            && b == 0) || (c == 6 && i == 3 && b == 0)
                            || ((c == 3 || c == 7) && i == 4 && s == 1);
                        @(posedge pclk) ev <= 5'h01 << i;
                        @(posedge pclk) ev <= 5'h00;
                        @(posedge pclk);
                        if (c == 3 || c == 7)
                            chk("clear_sync", {31'h0, count_clear}, {31'h0, x});
                        else if ((c == 5 || c == 6) && b == 1)
                            chk("clear_buf", {31'h0, count_clear}, {31'h0, x});
                        else if (c == 5 || c == 6)
                            chk("clear_cd", {31'h0, count_clear}, {31'h0, x});
                        else
                            chk("clear_ab", {31'h0, count_clear}, {31'h0, x});
                        chk("sync_out", {31'h0, sync_clear_out}, {31'h0, x && s == 1});
                    end
                end
    endtask

    task automatic t_reset();
        apb(1, `TCC_OFF_CONTROL, 32'h0000_00E7);
        @(posedge pclk) presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `TCC_OFF_CONTROL, 0);
        chk("ctl_rerun", rd, 32'h0000_0000);
    endtask

    task automatic t_phase();
        int c;
        apb(1, `TCC_OFF_MODE, 1);
        apb(1, `TCC_OFF_CONTROL, 32'h0000_0018);
        counter_run <= 1'b1;
        cnt(40, c);
        chk("phase_idle", c, 0);
        @(posedge pclk) phase_step <= 1'b1;
        @(posedge pclk) phase_step <= 1'b0;
        @(posedge pclk);
        chk("phase_step", {31'h0, count_inc}, 32'h0000_0001);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #400000;
        err_count++;
        complete_run();
    end

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_rates();
        t_clears();
        t_reset();
        t_phase();
        complete_run();
    end
endmodule // tcc_timer_clock_clear_bench
